// *** hdl/epp_ctrl.v ***
// Purpose: Host-side controller that reads, identifies and programs an EPROM
// Assumes: Pins of the device are driven directly; supplies switched by enables
// Notes:   One command at a time; o_ready low while busy
`timescale 1ns/1ps
`default_nettype none
`include "epp_defines.vh"

// Functional notes
// R1: Drive chip select low for every read and signature access.
// R2: Hold chip select high while idle so the device stands by.
// R3: Keep output drive high whenever the host drives the data lines.
// R4: Sample read data only after address and output-drive delays have elapsed.
// R5: Signature read: chip select and output drive low, bit nine high voltage.
// R6: Device returns maker code at bit zero low, part code when high.
// R7: Erased bytes read all ones; only zeros can be programmed.
// R8: Programming: both controls high, low supply raised, then programming supply.
// R9: With address and data stable, pulse chip select low to program.
// R10: Device programs only zero bits of the data pattern.
// R11: Verify with chip select high and output drive falling to low.
// R12: Fast pulses last 100 us, inside 95 to 105 us.
// R13: Adaptive initial pulses last 1 ms, inside 0.95 to 1.05 ms.
// R14: Adaptive overprogram pulse lasts 2.85 to 78.5 ms.
// R15: Fast pulse method is the default choice.
// R16: Device stays deselected and high impedance when both controls high.
// R17: Repeat pulse and verify until read-back matches, then finish byte.
// R18: Stop after bounded pulses per byte and report failure.
module epp_ctrl #(
   parameter ADDR_W = 15,
   parameter DATA_W = 8,
   parameter FAST_MAX_TRIES = `EPP_FAST_MAX_TRIES,
   parameter SLOW_MAX_TRIES = `EPP_SLOW_MAX_TRIES,
   parameter FAST_PULSE_CYC = `EPP_FAST_PULSE_US * `EPP_CLK_MHZ,
   parameter SLOW_PULSE_CYC = `EPP_SLOW_PULSE_US * `EPP_CLK_MHZ,
   parameter OVP_MIN_CYC = `EPP_OVP_MIN_US * `EPP_CLK_MHZ,
   parameter OVP_MAX_CYC = `EPP_OVP_MAX_US * `EPP_CLK_MHZ
) (
   input wire i_core_clk,
   input wire i_rst_b,
   // Command port: 0 read, 1 signature, 2 program
   input wire i_cmd_valid,
   input wire [1:0] i_cmd_op,
   input wire i_cmd_slow,
   input wire [ADDR_W-1:0] i_cmd_addr,
   input wire [DATA_W-1:0] i_cmd_data,
   output wire o_ready,
   output reg o_done,
   output reg o_fail,
   output reg [DATA_W-1:0] o_rdata,
   // Device pins
   output reg [ADDR_W-1:0] o_addr,
   output reg o_sig_hv_en,
   output reg o_chip_sel_b,
   output reg o_out_drive_b,
   input wire [DATA_W-1:0] i_data_lines,
   output reg [DATA_W-1:0] o_data_lines,
   output reg o_data_lines_oe,
   output reg o_vcc_prog_en,
   output reg o_vpp_prog_en
);

   localparam OP_READ = 2'h0;
   localparam OP_SIG = 2'h1;
   localparam OP_PROG = 2'h2;

   // Cycle counts; read and float delays round up, setup time is exact
   localparam [31:0] RD_CYC = (`EPP_TACC_NS * `EPP_CLK_MHZ + 999) / 1000;
   localparam [31:0] DF_CYC = (`EPP_TDF_NS * `EPP_CLK_MHZ + 999) / 1000;
   localparam [31:0] SU_CYC = `EPP_TSETUP_US * `EPP_CLK_MHZ;

   localparam [3:0] ST_IDLE = 4'h0;
   localparam [3:0] ST_RD_WAIT = 4'h1;
   localparam [3:0] ST_RD_END = 4'h2;
   localparam [3:0] ST_VCC_UP = 4'h3;
   localparam [3:0] ST_VPP_UP = 4'h4;
   localparam [3:0] ST_SETUP = 4'h5;
   localparam [3:0] ST_PULSE = 4'h6;
   localparam [3:0] ST_HOLD = 4'h7;
   localparam [3:0] ST_VERIFY = 4'h8;
   localparam [3:0] ST_OVP = 4'h9;
   localparam [3:0] ST_OVP_HOLD = 4'ha;
   localparam [3:0] ST_VPP_DN = 4'hb;
   localparam [3:0] ST_VCC_DN = 4'hc;

   reg [3:0] state;
   reg [31:0] timer;
   reg [7:0] tries;
   reg slow;
   reg over;
   reg ok;
   reg [DATA_W-1:0] wdata;
   reg [31:0] ovp_len;

   assign o_ready = (state == ST_IDLE);

   // Overprogram length: factor times pulses used, clamped to legal window
   always @* begin
      ovp_len = `EPP_OVP_FACTOR * SLOW_PULSE_CYC * {24'h000000, tries};
      if (ovp_len < OVP_MIN_CYC)
         ovp_len = OVP_MIN_CYC; // [R14]
      if (ovp_len > OVP_MAX_CYC)
         ovp_len = OVP_MAX_CYC; // [R14]
   end

   // ===========================================================
   // Sequencer
   always @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state <= ST_IDLE;
         timer <= 32'h00000000;
         tries <= 8'h00;
         slow <= 1'b0;
         over <= 1'b0;
         ok <= 1'b0;
         wdata <= 8'hff;
         o_done <= 1'b0;
         o_fail <= 1'b0;
         o_rdata <= 8'h00;
         o_addr <= 15'h0000;
         o_sig_hv_en <= 1'b0;
         o_chip_sel_b <= 1'b1;
         o_out_drive_b <= 1'b1;
         o_data_lines <= 8'hff;
         o_data_lines_oe <= 1'b0;
         o_vcc_prog_en <= 1'b0;
         o_vpp_prog_en <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (timer != 32'h00000000)
            timer <= timer - 32'h00000001;
         case (state)
         ST_IDLE: begin
            o_chip_sel_b <= 1'b1; // [R2]
            o_out_drive_b <= 1'b1;
            if (i_cmd_valid) begin
               o_fail <= 1'b0;
               if (i_cmd_op == OP_PROG) begin
                  o_addr <= i_cmd_addr;
                  wdata <= i_cmd_data;
                  slow <= i_cmd_slow; // Fast unless asked [R15]
                  tries <= 8'h00;
                  over <= 1'b0;
                  o_vcc_prog_en <= 1'b1; // Low supply first [R8]
                  timer <= SU_CYC;
                  state <= ST_VCC_UP;
               end else begin
                  if (i_cmd_op == OP_SIG) begin
                     // Other bits low; bit zero picks maker or part [R5] [R6]
                     o_addr <= i_cmd_addr[0] ? `EPP_SIG_PART_ADDR : `EPP_SIG_MAKER_ADDR;
                     o_sig_hv_en <= 1'b1; // [R5]
                  end else begin
                     o_addr <= i_cmd_addr;
                  end
                  o_data_lines_oe <= 1'b0;
                  o_chip_sel_b <= 1'b0; // [R1]
                  o_out_drive_b <= 1'b0;
                  timer <= RD_CYC; // Covers access and drive delay [R4]
                  state <= ST_RD_WAIT;
               end
            end
         end
         ST_RD_WAIT: begin
            if (timer == 32'h00000000) begin
               o_rdata <= i_data_lines; // [R4]
               o_chip_sel_b <= 1'b1;
               o_out_drive_b <= 1'b1; // [R3]
               o_sig_hv_en <= 1'b0;
               timer <= DF_CYC; // Let the device float its outputs
               state <= ST_RD_END;
            end
         end
         ST_RD_END: begin
            if (timer == 32'h00000000) begin
               o_done <= 1'b1;
               state <= ST_IDLE;
            end
         end
         ST_VCC_UP: begin
            if (timer == 32'h00000000) begin
               o_vpp_prog_en <= 1'b1; // Programming supply second [R8]
               timer <= SU_CYC;
               state <= ST_VPP_UP;
            end
         end
         ST_VPP_UP: begin
            if (timer == 32'h00000000) begin
               // Both controls high while data is driven [R16] [R3]
               o_data_lines <= wdata; // Zero bits are the ones to burn [R10]
               o_data_lines_oe <= 1'b1;
               timer <= SU_CYC;
               state <= ST_SETUP;
            end
         end
         ST_SETUP: begin
            if (timer == 32'h00000000) begin
               o_chip_sel_b <= 1'b0; // Address and data now stable [R9]
               tries <= tries + 8'h01;
               timer <= slow ? SLOW_PULSE_CYC - 1 : FAST_PULSE_CYC - 1; // [R12] [R13]
               state <= ST_PULSE;
            end
         end
         ST_PULSE: begin
            if (timer == 32'h00000000) begin
               o_chip_sel_b <= 1'b1;
               timer <= SU_CYC; // Data hold before releasing bus
               state <= ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (timer == 32'h00000000) begin
               o_data_lines_oe <= 1'b0;
               o_out_drive_b <= 1'b0; // Chip select stays high [R11]
               timer <= RD_CYC + DF_CYC;
               state <= ST_VERIFY;
            end
         end
         ST_VERIFY: begin
            if (timer == 32'h00000000) begin
               o_rdata <= i_data_lines;
               o_out_drive_b <= 1'b1;
               ok <= (i_data_lines == wdata); // [R11] [R17]
               timer <= SU_CYC;
               if (i_data_lines == wdata && slow && !over) begin
                  o_data_lines_oe <= 1'b1;
                  state <= ST_OVP;
               end else if (i_data_lines == wdata) begin
                  state <= ST_VPP_DN;
               end else if (tries >= (slow ? SLOW_MAX_TRIES : FAST_MAX_TRIES)) begin
                  state <= ST_VPP_DN; // Give up [R18]
               end else begin
                  o_data_lines_oe <= 1'b1;
                  state <= ST_SETUP; // Another pulse [R17]
               end
            end
         end
         ST_OVP: begin
            if (timer == 32'h00000000) begin
               o_chip_sel_b <= 1'b0; // [R14]
               over <= 1'b1;
               timer <= ovp_len - 1;
               state <= ST_OVP_HOLD;
            end
         end
         ST_OVP_HOLD: begin
            if (timer == 32'h00000000) begin
               o_chip_sel_b <= 1'b1;
               timer <= SU_CYC;
               state <= ST_HOLD; // Final verify after overprogram
            end
         end
         ST_VPP_DN: begin
            if (timer == 32'h00000000) begin
               o_vpp_prog_en <= 1'b0; // Reverse order on the way down
               timer <= SU_CYC;
               state <= ST_VCC_DN;
            end
         end
         ST_VCC_DN: begin
            if (timer == 32'h00000000) begin
               o_vcc_prog_en <= 1'b0;
               o_fail <= !ok; // [R18]
               o_done <= 1'b1;
               state <= ST_IDLE;
            end
         end
         default: begin
            state <= ST_IDLE;
         end
         endcase
      end
   end

endmodule
`default_nettype wire

// *** common/epp_defines.vh ***
// Purpose: Constants for the EPROM read and program controller
// Assumes: 50 MHz core clock, 20 ns period
// Notes:   Times are kept in their own unit; cycle counts derive from them
`ifndef EPP_DEFINES_VH
`define EPP_DEFINES_VH

`define EPP_CLK_MHZ 50
// Read timing, nanoseconds: access time, output-drive delay and float delay
`define EPP_TACC_NS 120
`define EPP_TOE_NS 50
`define EPP_TDF_NS 130
// Setup and hold around program pulses, microseconds
`define EPP_TSETUP_US 2
// Fast pulse, nominal 100 us within 95..105 us
`define EPP_FAST_PULSE_US 100
// Adaptive pulse, nominal 1 ms within 0.95..1.05 ms
`define EPP_SLOW_PULSE_US 1000
// Overprogram pulse is three times the pulse sum, bounded 2.85..78.5 ms
`define EPP_OVP_MIN_US 2850
`define EPP_OVP_MAX_US 78500
`define EPP_OVP_FACTOR 3
// Retry limits per byte
`define EPP_FAST_MAX_TRIES 25
`define EPP_SLOW_MAX_TRIES 25
// Fixed read address pattern for the signature mode
`define EPP_SIG_MAKER_ADDR 15'h0000
`define EPP_SIG_PART_ADDR 15'h0001
// All-ones erased byte
`define EPP_ERASED_BYTE 8'hff

`endif

// *** tb/epp_props.sv ***
// Purpose: Port checker for the EPROM controller
// Assumes: One clock, async active-low reset
// Notes:   Watches device pins and command handshake only
`timescale 1ns/1ps
`default_nettype none
// ==========
// Checker
module epp_props #(
   parameter FAST_PULSE_CYC = 20,
   parameter SLOW_PULSE_CYC = 40,
   parameter OVP_MIN_CYC = 60,
   parameter OVP_MAX_CYC = 200
) (
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic o_ready,
   input wire logic o_done,
   input wire logic [14:0] o_addr,
   input wire logic o_sig_hv_en,
   input wire logic o_chip_sel_b,
   input wire logic o_out_drive_b,
   input wire logic o_data_lines_oe,
   input wire logic o_vcc_prog_en,
   input wire logic o_vpp_prog_en
);
   logic [31:0] lo_cnt;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);
   // Length of the current chip-select low stretch
   always @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) lo_cnt <= 32'h0;
      else if (o_chip_sel_b) lo_cnt <= 32'h0;
      else lo_cnt <= lo_cnt + 32'h1;
   end
   AST_IDLE_STANDBY: assert property (o_ready |-> o_chip_sel_b && !o_vpp_prog_en)
      else $error("chip select low while idle");
   AST_BUS_TURN: assert property (o_data_lines_oe |-> o_out_drive_b)
      else $error("host drives data with outputs enabled");
   AST_SUPPLY_ORDER: assert property (o_vpp_prog_en |-> o_vcc_prog_en)
      else $error("programming supply without low supply");
   AST_SIG_ADDR: assert property (o_sig_hv_en |-> o_addr[14:1] == 14'h0 && !o_vcc_prog_en)
      else $error("signature address pattern wrong");
   AST_PULSE_SETUP: assert property ($fell(o_chip_sel_b) && o_vpp_prog_en |->
      o_data_lines_oe && o_out_drive_b && $stable(o_addr) && $past(o_data_lines_oe, 50))
      else $error("program pulse without stable data");
   AST_PULSE_WIDTH: assert property ($rose(o_chip_sel_b) && o_vpp_prog_en |->
      lo_cnt == FAST_PULSE_CYC || lo_cnt == SLOW_PULSE_CYC ||
      (lo_cnt >= OVP_MIN_CYC && lo_cnt <= OVP_MAX_CYC))
      else $error("program pulse width wrong");
   AST_VERIFY_CS: assert property (o_vpp_prog_en && !o_out_drive_b |-> o_chip_sel_b)
      else $error("verify with chip select low");
   // Ready stands with the done pulse; the next command may be taken at once
   AST_DONE_READY: assert property (o_done |-> o_ready ##1 !o_done)
      else $error("done not followed by ready");
   AST_PROG_ENTRY: assert property ($rose(o_vcc_prog_en) |-> o_chip_sel_b && o_out_drive_b)
      else $error("supply raised with a control low");
endmodule
bind epp_ctrl epp_props #(.FAST_PULSE_CYC(FAST_PULSE_CYC), .SLOW_PULSE_CYC(SLOW_PULSE_CYC),
   .OVP_MIN_CYC(OVP_MIN_CYC), .OVP_MAX_CYC(OVP_MAX_CYC)) u_props (
   .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .o_ready(o_ready), .o_done(o_done),
   .o_addr(o_addr), .o_sig_hv_en(o_sig_hv_en), .o_chip_sel_b(o_chip_sel_b),
   .o_out_drive_b(o_out_drive_b), .o_data_lines_oe(o_data_lines_oe),
   .o_vcc_prog_en(o_vcc_prog_en), .o_vpp_prog_en(o_vpp_prog_en));
`default_nettype wire

// *** tb/epp_dev_model.sv ***
// Purpose: Behavioural EPROM seen from its pins
// Assumes: Output delay of 50 ns after enable
// Notes:   Undriven data shows the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
// ==========
// Device model
module epp_dev_model #(
   parameter MAKER_CODE = 8'h5a, // Arbitrary value
   parameter PART_CODE = 8'h3c // Arbitrary value
) (
   input wire logic [14:0] i_addr,
   input wire logic i_sig_hv,
   input wire logic i_cs_b,
   input wire logic i_oe_b,
   input wire logic i_vpp,
   input wire logic [7:0] i_host_d,
   input wire logic i_host_oe,
   input wire logic [7:0] i_stuck,
   output logic [7:0] o_q
);
   logic [7:0] mem [0:32767];
   logic [7:0] val;
   logic [7:0] last;
   logic en;
   initial for (int k = 0; k < 32768; k++) mem[k] = 8'hff;
   // Read when selected, verify with select high under program supply
   assign en = !i_oe_b && (i_vpp ? i_cs_b : !i_cs_b);
   always @* val = i_sig_hv ? (i_addr[0] ? PART_CODE : MAKER_CODE) : mem[i_addr];
   always @(val or en) if (en) last = val;
   assign #50 o_q = en ? val : ~last;
   // Stuck bits stand for cells that refuse to program
   always @(negedge i_cs_b) begin
      if (i_vpp && i_oe_b && i_host_oe) mem[i_addr] <= mem[i_addr] & (i_host_d | i_stuck);
   end
endmodule
`default_nettype wire

// *** tb/epp_ctrl_test.sv ***
// Purpose: Self-checking bench for the EPROM controller
// Assumes: Shortened pulse parameters
// Notes:   Random addresses and data from a fixed seed
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench
module epp_ctrl_test;
   localparam logic [7:0] MK = 8'h5a; // Arbitrary value
   localparam logic [7:0] PT = 8'h3c; // Arbitrary value
   logic clk = 0, rst_b = 0, vld = 0, slow = 0;
   logic [1:0] op = 0;
   logic [14:0] a = 0, addr;
   logic [7:0] d = 0, d1, d2, rdata, q, hd, stuck = 0;
   logic rdy, done, fail, hv, cs_b, oe_b, hoe, vcc, vpp;
   integer seed = 32'hd73c, mismatches = 0, num_checks = 0, cycles = 0;
   epp_ctrl #(.FAST_PULSE_CYC(20), .SLOW_PULSE_CYC(40), .OVP_MIN_CYC(60), .OVP_MAX_CYC(200))
   dut_u (.i_core_clk(clk), .i_rst_b(rst_b), .i_cmd_valid(vld), .i_cmd_op(op),
      .i_cmd_slow(slow), .i_cmd_addr(a), .i_cmd_data(d), .o_ready(rdy), .o_done(done),
      .o_fail(fail), .o_rdata(rdata), .o_addr(addr), .o_sig_hv_en(hv), .o_chip_sel_b(cs_b),
      .o_out_drive_b(oe_b), .i_data_lines(hoe ? hd : q), .o_data_lines(hd),
      .o_data_lines_oe(hoe), .o_vcc_prog_en(vcc), .o_vpp_prog_en(vpp));
   epp_dev_model #(.MAKER_CODE(MK), .PART_CODE(PT)) dev_u (.i_addr(addr), .i_sig_hv(hv),
      .i_cs_b(cs_b), .i_oe_b(oe_b), .i_vpp(vpp), .i_host_d(hd), .i_host_oe(hoe),
      .i_stuck(stuck), .o_q(q));
   initial forever #10 clk = ~clk;
   // Cut a hang short well past the longest expected run
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles >= 60000) begin
         mismatches = mismatches + 1;
         end_sim;
      end
   end
   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task check(input string nm, input logic [7:0] e, input logic [7:0] g);
      num_checks = num_checks + 1;
      if (g !== e) begin
         mismatches = mismatches + 1;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Stored byte after a burn: zeros land unless the cell is stuck at one
   function automatic logic [7:0] burn(input logic [7:0] was, input logic [7:0] want,
      input logic [7:0] stk);
      return was & (want | stk);
   endfunction
   // One command, handed over at a falling edge, waited for under a bound
   task cmd(input logic [1:0] o, input logic s, input logic [14:0] ad, input logic [7:0] dt);
      integer n;
      n = 0;
      while (rdy !== 1'b1) @(negedge clk);
      vld = 1;
      op = o;
      slow = s;
      a = ad;
      d = dt;
      @(negedge clk);
      vld = 0;
      while (done !== 1'b1 && n < 20000) begin
         @(negedge clk);
         n = n + 1;
      end
      check("done", 8'h01, {7'h0, done});
   endtask
   initial begin
      repeat (20) @(negedge clk);
      rst_b = 1;
      for (int i = 0; i < 4; i++) begin
         cmd(2'd0, 1'b0, {4'h0, 11'($random(seed))}, 8'h00);
         check("erased", 8'hff, rdata);
      end
      cmd(2'd1, 1'b0, 15'h0000, 8'h00);
      check("maker", MK, rdata);
      cmd(2'd1, 1'b0, 15'h0001, 8'h00);
      check("part", PT, rdata);
      for (int i = 0; i < 4; i++) begin
         a = {4'(4 + i), 11'($random(seed))};
         // The task overwrites d, so the bytes to burn live in d1 and d2
         d1 = 8'($random(seed));
         d2 = (i == 3) ? 8'h00 : 8'($random(seed));
         cmd(2'd2, i[0], a, d1);
         check("fail", 8'h00, {7'h0, fail});
         cmd(2'd0, 1'b0, a, 8'h00);
         check("byte", burn(8'hff, d1, 8'h00), rdata);
         cmd(2'd2, ~i[0], a, d2);
         check("refail", {7'h0, burn(d1, d2, 8'h00) != d2}, {7'h0, fail});
         cmd(2'd0, 1'b0, a, 8'h00);
         check("merge", burn(d1, d2, 8'h00), rdata);
      end
      stuck = 8'h81;
      cmd(2'd2, 1'b0, {4'hc, 11'($random(seed))}, 8'h00);
      check("gave up", 8'h01, {7'h0, fail});
      check("verify", burn(8'hff, 8'h00, stuck), rdata);
      stuck = 8'h00;
      end_sim;
   end
endmodule
`default_nettype wire
